// ---- ckcfg_defines.svh ----
// ckcfg_defines.svh: offsets, field positions, reset values and counts of the
// serial configuration receiver.
// assumes: included by bare name by the package and the design module.
`ifndef CKCFG_DEFINES_SVH
`define CKCFG_DEFINES_SVH

`define CKCFG_SLAVE_ADDR      8'hD2
`define CKCFG_FRAME_BYTES     4'hB
`define CKCFG_FIRST_DATA      4'h3
`define CKCFG_DATA_BYTES      8
`define CKCFG_BIT_LAST        3'h7
`define CKCFG_BYTE0_RESET     8'h00
`define CKCFG_BYTE1_RESET     8'h0B
`define CKCFG_BYTEN_RESET     8'hFF
`define CKCFG_SEL_LSB         4
`define CKCFG_SWSEL_BIT       3
`define CKCFG_MODE_LSB        0
`define CKCFG_MODE_TRISTATE   2'h3
`define CKCFG_SEL_STEP_US     20
`define CKCFG_CLK_MHZ         25
`define CKCFG_SEL_STEP_CYC    (`CKCFG_SEL_STEP_US * `CKCFG_CLK_MHZ)

`endif

// ---- ckcfg_pkg.sv ----
// ckcfg_pkg.sv: types of the serial configuration receiver.
// assumes: ckcfg_defines.svh is on the include path.
`include "ckcfg_defines.svh"

package ckcfg_pkg;

    typedef enum logic [1:0] {
        CKCFG_IDLE,
        CKCFG_BITS,
        CKCFG_ACK,
        CKCFG_SKIP
    } ckcfg_state_t;

    // control outputs toward the clock synthesis core
    typedef struct packed {
        logic [63:0] out_enable;  // one bit per output, 1 runs, 0 held low
        logic        tristate;    // all outputs high impedance
        logic        sw_select;   // software frequency select active
        logic [2:0]  freq_sel;    // software frequency code, stepped
        logic        spread_on;   // modulation, on from the first enabled cycle after reset
    } ckcfg_ctrl_t;

endpackage

// ---- ckcfg_rx.sv ----
// ckcfg_rx.sv: write-only two-wire configuration receiver with control registers.
// assumes: serial clock and data come from a host master outside this clock
// domain; the pad merges data output enable into an open-drain wire.
`timescale 1ns/1ns
`default_nettype none
`include "ckcfg_defines.svh"

module ckcfg_rx (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    input  wire logic                 serial_cfg_clock_pin,
    input  wire logic                 serial_cfg_data_pin_i,
    output var  logic                 serial_cfg_data_pin_o,
    output var  logic                 serial_cfg_data_pin_oe,
    output var  ckcfg_pkg::ckcfg_ctrl_t ctrl,
    output var  logic                 center_spread,
    output var  logic                 frame_done
);
    import ckcfg_pkg::*;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [1:0]   scl_sync_q;
    logic [1:0]   sda_sync_q;
    logic         scl_prev_q;
    logic         sda_prev_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else if (ce) begin
            scl_sync_q <= {scl_sync_q[0], serial_cfg_clock_pin};
            sda_sync_q <= {sda_sync_q[0], serial_cfg_data_pin_i};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
        end
    end

    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    assign scl        = scl_sync_q[1];
    assign sda        = sda_sync_q[1];
    assign scl_rise   = scl & ~scl_prev_q;
    assign scl_fall   = ~scl & scl_prev_q;
    assign start_cond = scl & scl_prev_q & sda_prev_q & ~sda;
    assign stop_cond  = scl & scl_prev_q & ~sda_prev_q & sda;

    // ****************************************************************
    // byte receiver
    // ****************************************************************
    ckcfg_state_t state_q;
    logic [7:0]   shift_q;
    logic [2:0]   bit_q;
    logic [3:0]   pos_q;
    logic         ack_q;
    logic         full_q;
    logic         byte_done;

    // the fall after a start carries no bit: a byte ends at the fall after its eighth rise
    assign byte_done = (state_q == CKCFG_BITS) && scl_fall && full_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= CKCFG_IDLE;
            shift_q <= 8'h00;
            bit_q   <= 3'h0;
            pos_q   <= 4'h0;
            ack_q   <= 1'b0;
            full_q  <= 1'b0;
        end else if (ce) begin
            if (start_cond) begin
                state_q <= CKCFG_BITS;
                bit_q   <= 3'h0;
                pos_q   <= 4'h0;
                ack_q   <= 1'b0;
                full_q  <= 1'b0;
            end else if (stop_cond) begin
                state_q <= CKCFG_IDLE;
                ack_q   <= 1'b0;
            end else begin
                case (state_q)
                    CKCFG_IDLE: begin
                        ack_q <= 1'b0;
                    end
                    CKCFG_BITS: begin
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda};
                            bit_q   <= bit_q + 3'h1;
                            full_q  <= (bit_q == `CKCFG_BIT_LAST);
                        end
                        if (byte_done) begin
                            full_q <= 1'b0;
                            if (pos_q == 4'h0 && shift_q != `CKCFG_SLAVE_ADDR) begin
                                state_q <= CKCFG_SKIP;
                            end else begin
                                state_q <= CKCFG_ACK;
                                ack_q   <= 1'b1;
                            end
                        end
                    end
                    CKCFG_ACK: begin
                        if (scl_fall) begin
                            ack_q   <= 1'b0;
                            pos_q   <= pos_q + 4'h1;
                            state_q <= (pos_q == `CKCFG_FRAME_BYTES - 4'h1) ?
                                       CKCFG_SKIP : CKCFG_BITS;
                        end
                    end
                    CKCFG_SKIP: begin
                        ack_q <= 1'b0;
                    end
                    default: begin
                        state_q <= CKCFG_IDLE;
                    end
                endcase
            end
        end
    end

    // open drain: only pulls low for ack, never shifts data out
    always_ff @(posedge clk) begin
        if (rst) begin
            serial_cfg_data_pin_o  <= 1'b0;
            serial_cfg_data_pin_oe <= 1'b0;
        end else if (ce) begin
            serial_cfg_data_pin_o  <= 1'b0;
            serial_cfg_data_pin_oe <= ack_q;
        end
    end

    // ****************************************************************
    // data byte registers
    // ****************************************************************
    logic [7:0] data_q [`CKCFG_DATA_BYTES];
    logic       wr_data;
    logic [3:0] data_idx;

    assign wr_data  = byte_done && (pos_q >= `CKCFG_FIRST_DATA);
    assign data_idx = pos_q - `CKCFG_FIRST_DATA;

    genvar gi;
    generate
        for (gi = 0; gi < `CKCFG_DATA_BYTES; gi++) begin : g_byte
            always_ff @(posedge clk) begin
                if (rst) begin
                    data_q[gi] <= (gi == 0) ? `CKCFG_BYTE0_RESET :
                                  (gi == 1) ? `CKCFG_BYTE1_RESET : `CKCFG_BYTEN_RESET;
                end else if (ce && wr_data && data_idx == 4'(gi)) begin
                    data_q[gi] <= shift_q;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            frame_done <= 1'b0;
        end else if (ce) begin
            frame_done <= byte_done && (pos_q == `CKCFG_FRAME_BYTES - 4'h1);
        end
    end

    // ****************************************************************
    // control outputs and frequency stepping
    // ****************************************************************
    logic [2:0]  sel_target;
    logic [15:0] step_cnt_q;
    logic [2:0]  sel_q;

    assign sel_target = data_q[0][`CKCFG_SEL_LSB +: 3];

    // walks one code step per interval toward the target
    always_ff @(posedge clk) begin
        if (rst) begin
            sel_q      <= 3'h0;
            step_cnt_q <= 16'h0000;
        end else if (ce) begin
            if (sel_q == sel_target) begin
                step_cnt_q <= 16'h0000;
            end else if (step_cnt_q == 16'(`CKCFG_SEL_STEP_CYC - 1)) begin
                step_cnt_q <= 16'h0000;
                sel_q      <= (sel_q < sel_target) ? sel_q + 3'h1 : sel_q - 3'h1;
            end else begin
                step_cnt_q <= step_cnt_q + 16'h0001;
            end
        end
    end

    logic [63:0] enables;
    always_comb begin
        enables = '1;
        enables[55:0] = {data_q[7], data_q[6], data_q[5], data_q[4],
                         data_q[3], data_q[2], data_q[1]};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl          <= '0;
            center_spread <= 1'b0;
        end else if (ce) begin
            ctrl.out_enable <= enables;
            ctrl.tristate   <= data_q[0][`CKCFG_MODE_LSB +: 2] == `CKCFG_MODE_TRISTATE;
            ctrl.sw_select  <= data_q[0][`CKCFG_SWSEL_BIT];
            ctrl.freq_sel   <= sel_q;
            ctrl.spread_on  <= 1'b1;
            center_spread   <= (sel_q == 3'h5) || (sel_q == 3'h1);
        end
    end

endmodule // ckcfg_rx
`default_nettype wire

// ---- ckcfg_rx_sva.sv ----
// ckcfg_rx_sva.sv: port assertions of the configuration receiver.
// assumes: bound to ckcfg_rx from the bench top file.
`timescale 1ns/1ns
`default_nettype none
module ckcfg_rx_sva (
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              serial_cfg_clock_pin,
    input wire logic              serial_cfg_data_pin_o,
    input wire logic              serial_cfg_data_pin_oe,
    input wire ckcfg_pkg::ckcfg_ctrl_t ctrl,
    input wire logic              center_spread,
    input wire logic              frame_done
);
    import ckcfg_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_never_drive_one: assert property (!serial_cfg_data_pin_o)
        else $error("data pin driven high");
    chk_spread_always: assert property (
        !$past(rst) && !$past(rst, 2) |-> ctrl.spread_on)
        else $error("modulation off");
    chk_done_single: assert property (frame_done |=> !frame_done)
        else $error("frame done too long");
    chk_top_enables: assert property (
        !$past(rst) && !$past(rst, 2) |-> ctrl.out_enable[63:56] == 8'hFF)
        else $error("spare enables cleared");
    chk_ack_hold: assert property (
        $rose(serial_cfg_data_pin_oe) |->
        serial_cfg_data_pin_oe[*4] ##[1:16] !serial_cfg_data_pin_oe)
        else $error("ack length wrong");
    chk_ack_clock_low: assert property (
        serial_cfg_clock_pin[*4] |-> $stable(serial_cfg_data_pin_oe))
        else $error("ack moved in clock high");
    chk_center_code: assert property (
        $stable(ctrl.freq_sel) && ctrl.freq_sel == $past(ctrl.freq_sel, 2) |->
        center_spread == (ctrl.freq_sel inside {3'h1, 3'h5}))
        else $error("spread kind wrong");
    chk_step_one: assert property (
        $changed(ctrl.freq_sel) |-> ctrl.freq_sel == $past(ctrl.freq_sel) + 3'h1 ||
        ctrl.freq_sel == $past(ctrl.freq_sel) - 3'h1)
        else $error("frequency jumped");
    chk_step_gap: assert property (
        $changed(ctrl.freq_sel) |=> $stable(ctrl.freq_sel)[*8])
        else $error("frequency steps too close");
endmodule // ckcfg_rx_sva
`default_nettype wire

// ---- ckcfg_host_model.sv ----
// ckcfg_host_model.sv: host master writing frames over the two-wire link.
// assumes: the wire is pulled up and either party may pull it low.
`timescale 1ns/1ns
`default_nettype none
module ckcfg_host_model (
    input  wire logic clk,
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // clock low 4, high 4; data changes only while low
    task automatic bit_out(input logic b, output logic a);
        scl <= 1'b0;
        tick(2);
        sda_low <= !b;
        tick(2);
        scl <= 1'b1;
        tick(2);
        @(negedge clk);
        a = !sda;
        tick(2);
    endtask
    task automatic send(input logic [87:0] f, input int n, output logic [10:0] acks);
        logic a;
        acks = '0;
        tick(4);
        sda_low <= 1'b1;
        tick(4);
        for (int k = 0; k < n; k++) begin
            for (int i = 7; i >= 0; i--) bit_out(f[80-8*k+i], a);
            bit_out(1'b1, a);
            acks[k] = a;
        end
        scl <= 1'b0;
        tick(2);
        sda_low <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b0;
        tick(4);
    endtask
endmodule // ckcfg_host_model
`default_nettype wire

// ---- ckcfg_rx_tb.sv ----
// ckcfg_rx_tb.sv: self-checking bench of the configuration receiver.
// assumes: package, design, checker and host model compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("FAIL t=%0t got %h exp %h", $time, (g), (e)); end end
module ckcfg_rx_tb;
    import ckcfg_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        sda_o, sda_oe, cs, fd;
    wire logic   scl, host_low;
    wire logic   sda = !(host_low || (sda_oe && !sda_o));
    ckcfg_ctrl_t ctrl;
    logic [10:0] acks;
    int          error_cnt = 0;
    int          total_checks = 0;
    int          done_cnt = 0;
    always #20 clk = ~clk;
    always @(negedge clk) if (fd === 1'b1) done_cnt++;
    ckcfg_rx uut (.clk(clk), .rst(rst), .ce(ce), .serial_cfg_clock_pin(scl),
        .serial_cfg_data_pin_i(sda), .serial_cfg_data_pin_o(sda_o),
        .serial_cfg_data_pin_oe(sda_oe), .ctrl(ctrl), .center_spread(cs), .frame_done(fd));
    ckcfg_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task do_reset;
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task wait_freq(input logic [2:0] f);
        for (int i = 0; i < 3000 && ctrl.freq_sel !== f; i++) @(negedge clk);
        repeat (2) @(negedge clk);
        `CHK(ctrl.freq_sel, f)
        if (ctrl.freq_sel !== f) close_out();
    endtask
    task t_defaults;
        `CHK(ctrl.out_enable, 64'hFFFF_FFFF_FFFF_FF0B)
        `CHK({ctrl.tristate, ctrl.sw_select, ctrl.freq_sel, ctrl.spread_on}, 6'h01)
        $display("test defaults done");
    endtask
    task t_write;
        logic [2:0] held;
        host.send(88'hD2_55_AA_38_0A_40_0F_11_22_44_81, 11, acks);
        `CHK(acks, 11'h7FF)
        `CHK(done_cnt, 1)
        `CHK(ctrl.out_enable, 64'hFF81_4422_110F_400A)
        `CHK({ctrl.sw_select, ctrl.tristate}, 2'h2)
        ce <= 1'b0;
        @(negedge clk);
        held = ctrl.freq_sel;
        repeat (600) @(posedge clk);
        `CHK(ctrl.freq_sel, held)
        ce <= 1'b1;
        wait_freq(3'h3);
        $display("test write done");
    endtask
    task t_bad;
        host.send(88'hD3_00_00_03_00_00_00_00_00_00_00, 11, acks);
        `CHK(acks, 11'h000)
        `CHK(done_cnt, 1)
        `CHK(ctrl.out_enable, 64'hFF81_4422_110F_400A)
        `CHK(ctrl.tristate, 1'b0)
        $display("test bad address done");
    endtask
    task t_modes;
        host.send(88'hD2_FF_01_1B_08_00_00_00_00_00_00, 11, acks);
        `CHK(acks, 11'h7FF)
        `CHK(done_cnt, 2)
        `CHK(ctrl.tristate, 1'b1)
        `CHK(ctrl.out_enable, 64'hFF00_0000_0000_0008)
        wait_freq(3'h1);
        `CHK(cs, 1'b1)
        $display("test modes done");
    endtask
    initial begin
        do_reset();
        t_defaults();
        t_write();
        t_bad();
        t_modes();
        do_reset();
        t_defaults();
        close_out();
    end
endmodule // ckcfg_rx_tb
bind ckcfg_rx ckcfg_rx_sva chk (.clk(clk), .rst(rst), .serial_cfg_clock_pin(serial_cfg_clock_pin),
    .serial_cfg_data_pin_o(serial_cfg_data_pin_o), .ctrl(ctrl),
    .serial_cfg_data_pin_oe(serial_cfg_data_pin_oe), .center_spread(center_spread),
    .frame_done(frame_done));
`default_nettype wire
